// ==== hw/acte_pkg.sv ====
// constants for the conversion timing and excitation control block
// assumes a 125 MHz core clock and an AXI4-Lite register master
// What the document specifies
// [R1] modulator clock is oscillator divided by four
// [R2] oscillator 1.024 MHz normal, 2.048 MHz fast
// [R3] filter settles within one conversion period
// [R4] rate and notches scale with oscillator
// [R5] continuous period between result_ready_n falling edges
// [R6] first conversion delayed 28.5 or 105 cycles
// [R7] continuous periods 51192 down to 1036 cycles
// [R8] single-shot time rounded up to whole cycle
// [R9] single-shot times per rate and mode table
// [R10] command latch moment depends on baud rate; here start latches when the command write completes
// [R11] magnitude field selects current, 000 disables
// [R12] two route fields, 000 leaves source unrouted
// [R13] host waits 200 us after setting magnitude
// [R14] sources stay on between shots, off on sleep
// [R15] bias on when magnitude nonzero, routed current flows
// [R16] burn-out sources 10 uA when enabled
// [R17] host enables burn-out only for fault checks
// [R18] result_ready_n falls per result, rises on read/start
// [R19] settings select mode, conversion mode and rate
package acte_pkg;
  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] ACTE_CFG_OFS = 8'h00;
  localparam logic [7:0] ACTE_EXC_OFS = 8'h04;
  localparam logic [7:0] ACTE_CMD_OFS = 8'h08;
  localparam logic [7:0] ACTE_STAT_OFS = 8'h0c;
  localparam logic [7:0] ACTE_IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] ACTE_IRQ_EN_OFS = 8'h14;
  localparam logic [7:0] ACTE_IRQ_CLR_OFS = 8'h18;
  localparam logic [7:0] ACTE_RESULT_OFS = 8'h1c;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int ACTE_CFG_FAST_BIT = 0;
  localparam int ACTE_CFG_SINGLE_BIT = 1;
  localparam int ACTE_CFG_RATE_LSB = 4;
  localparam int ACTE_EXC_MAG_LSB = 0;
  localparam int ACTE_EXC_R1_LSB = 4;
  localparam int ACTE_EXC_R2_LSB = 8;
  localparam int ACTE_EXC_BURN_BIT = 12;
  localparam int ACTE_CMD_START_BIT = 0;
  localparam int ACTE_CMD_SLEEP_BIT = 1;
  localparam int ACTE_IRQ_DONE_BIT = 0;
  localparam int ACTE_IRQ_START_BIT = 1;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [6:0] ACTE_CFG_RST = 7'h00;
  localparam logic [12:0] ACTE_EXC_RST = 13'h0000;
  localparam logic [1:0] ACTE_IRQ_EN_RST = 2'h0;
  // ************************************************************
  // timing: oscillator emulated by a fractional accumulator
  // ************************************************************
  localparam int ACTE_CORE_HZ = 125000000;
  localparam int ACTE_OSC_NORM_HZ = 1024000;
  localparam int ACTE_OSC_FAST_HZ = 2048000;
  localparam int ACTE_MOD_DIV = 4;
  // phase step per core cycle, in half oscillator periods (2^24 per half)
  localparam logic [31:0] ACTE_STEP_NORM =
    32'((64'(ACTE_OSC_NORM_HZ) * 2 * 64'h1000000) / ACTE_CORE_HZ);
  localparam logic [31:0] ACTE_STEP_FAST =
    32'((64'(ACTE_OSC_FAST_HZ) * 2 * 64'h1000000) / ACTE_CORE_HZ);
  // start delays in half oscillator periods
  localparam logic [17:0] ACTE_FIRST_HALF_NORM = 18'h00039; // 28.5 cycles
  localparam logic [17:0] ACTE_FIRST_HALF_FAST = 18'h000d2; // 105 cycles
  // conversion lengths in oscillator cycles, rate index 0 is the slowest
  localparam logic [16:0] ACTE_CONT_0 = 17'd51192;
  localparam logic [16:0] ACTE_CONT_1 = 17'd22780;
  localparam logic [16:0] ACTE_CONT_2 = 17'd11532;
  localparam logic [16:0] ACTE_CONT_3 = 17'd5916;
  localparam logic [16:0] ACTE_CONT_4 = 17'd3116;
  localparam logic [16:0] ACTE_CONT_5 = 17'd1724;
  localparam logic [16:0] ACTE_CONT_6 = 17'd1036;
  localparam logic [16:0] ACTE_SHOT_N_0 = 17'd51213;
  localparam logic [16:0] ACTE_SHOT_N_1 = 17'd22805;
  localparam logic [16:0] ACTE_SHOT_N_2 = 17'd11557;
  localparam logic [16:0] ACTE_SHOT_N_3 = 17'd5941;
  localparam logic [16:0] ACTE_SHOT_N_4 = 17'd3141;
  localparam logic [16:0] ACTE_SHOT_N_5 = 17'd1749;
  localparam logic [16:0] ACTE_SHOT_N_6 = 17'd1061;
  localparam logic [16:0] ACTE_SHOT_F_0 = 17'd51217;
  localparam logic [16:0] ACTE_SHOT_F_1 = 17'd22809;
  localparam logic [16:0] ACTE_SHOT_F_2 = 17'd11561;
  localparam logic [16:0] ACTE_SHOT_F_3 = 17'd5945;
  localparam logic [16:0] ACTE_SHOT_F_4 = 17'd3145;
  localparam logic [16:0] ACTE_SHOT_F_5 = 17'd1753;
  localparam logic [16:0] ACTE_SHOT_F_6 = 17'd1065;
  localparam int ACTE_EXC_STARTUP_US = 200;
  typedef enum logic [1:0] {ACTE_IDLE, ACTE_DELAY, ACTE_CONV} acte_state_t;
endpackage

// ==== hw/acte_ctrl.sv ====
// conversion sequencer, excitation gating and AXI4-Lite register slave
// assumes one 125 MHz clock and a master that keeps one write and one read open
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
module acte_ctrl (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic RESULT_READY_N,
  output logic MOD_CLK,
  output logic EXC_BIAS_ON,
  output logic [2:0] EXCITATION_MAGNITUDE,
  output logic [2:0] EXCITATION1_ROUTE,
  output logic [2:0] EXCITATION2_ROUTE,
  output logic BURNOUT_ENABLE,
  output logic IRQ
);
  // ************************************************************
  // state and helpers
  // ************************************************************
  typedef struct packed {
    logic aw_done;
    logic [7:0] aw_addr;
    logic w_done;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [6:0] cfg;
    logic [12:0] exc;
    logic powered;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    acte_pkg::acte_state_t st;
    logic [31:0] phase;
    logic [17:0] half_cnt;
    logic osc;
    logic [1:0] mod_div;
    logic mod_clk;
    logic rdy_n;
    logic [7:0] result_cnt;
  } acte_regs_t;

  acte_regs_t cur_r;
  acte_regs_t cur_nxt;

  // conversion length in oscillator cycles from rate index [R7] [R9]
  function automatic logic [16:0] acte_conv_len(input logic [2:0] rate,
                                                input logic single, input logic fast);
    logic [16:0] cont;
    logic [16:0] shot_n;
    logic [16:0] shot_f;
    begin
      case (rate)
        3'h0:
        begin
          cont = acte_pkg::ACTE_CONT_0;
          shot_n = acte_pkg::ACTE_SHOT_N_0;
          shot_f = acte_pkg::ACTE_SHOT_F_0;
        end
        3'h1:
        begin
          cont = acte_pkg::ACTE_CONT_1;
          shot_n = acte_pkg::ACTE_SHOT_N_1;
          shot_f = acte_pkg::ACTE_SHOT_F_1;
        end
        3'h2:
        begin
          cont = acte_pkg::ACTE_CONT_2;
          shot_n = acte_pkg::ACTE_SHOT_N_2;
          shot_f = acte_pkg::ACTE_SHOT_F_2;
        end
        3'h3:
        begin
          cont = acte_pkg::ACTE_CONT_3;
          shot_n = acte_pkg::ACTE_SHOT_N_3;
          shot_f = acte_pkg::ACTE_SHOT_F_3;
        end
        3'h4:
        begin
          cont = acte_pkg::ACTE_CONT_4;
          shot_n = acte_pkg::ACTE_SHOT_N_4;
          shot_f = acte_pkg::ACTE_SHOT_F_4;
        end
        3'h5:
        begin
          cont = acte_pkg::ACTE_CONT_5;
          shot_n = acte_pkg::ACTE_SHOT_N_5;
          shot_f = acte_pkg::ACTE_SHOT_F_5;
        end
        // index 7 is treated as the fastest rate
        default:
        begin
          cont = acte_pkg::ACTE_CONT_6;
          shot_n = acte_pkg::ACTE_SHOT_N_6;
          shot_f = acte_pkg::ACTE_SHOT_F_6;
        end
      endcase
      // single-shot times hold the latch overhead, already whole cycles [R8]
      if (!single)
        acte_conv_len = cont;
      else if (fast)
        acte_conv_len = shot_f;
      else
        acte_conv_len = shot_n;
    end
  endfunction

  // byte-lane merge shared by every writable register
  function automatic logic [31:0] acte_merge(input logic [31:0] old,
                                             input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    begin
      r = old;
      for (int i = 0; i < 4; i++)
        if (st[i])
          r[i*8 +: 8] = wd[i*8 +: 8];
      acte_merge = r;
    end
  endfunction

  logic wr_go;
  logic rd_go;
  logic [31:0] wval;
  logic start_cmd;
  logic sleep_cmd;
  logic osc_tick;
  logic [32:0] phase_sum;
  logic [2:0] rate;
  logic fast;
  logic single;
  logic done_ev;
  logic start_ev;
  logic result_read;

  assign rate = cur_r.cfg[acte_pkg::ACTE_CFG_RATE_LSB +: 3];
  assign fast = cur_r.cfg[acte_pkg::ACTE_CFG_FAST_BIT];
  assign single = cur_r.cfg[acte_pkg::ACTE_CFG_SINGLE_BIT];
  assign wr_go = cur_r.aw_done && cur_r.w_done && !cur_r.bvalid;
  assign rd_go = S_AXI_ARVALID && !cur_r.rvalid;

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb
  begin
    cur_nxt = cur_r;
    wval = acte_merge(32'h0, cur_r.w_data, cur_r.w_strb);
    start_cmd = 1'b0;
    sleep_cmd = 1'b0;
    done_ev = 1'b0;
    start_ev = 1'b0;
    result_read = 1'b0;
    // address and data taken in either order
    if (S_AXI_AWVALID && !cur_r.aw_done)
    begin
      cur_nxt.aw_done = 1'b1;
      cur_nxt.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !cur_r.w_done)
    begin
      cur_nxt.w_done = 1'b1;
      cur_nxt.w_data = S_AXI_WDATA;
      cur_nxt.w_strb = S_AXI_WSTRB;
    end
    if (cur_r.bvalid && S_AXI_BREADY)
      cur_nxt.bvalid = 1'b0;
    if (cur_r.rvalid && S_AXI_RREADY)
      cur_nxt.rvalid = 1'b0;
    // write decode; settings steer the timing [R19]
    if (wr_go)
    begin
      cur_nxt.aw_done = 1'b0;
      cur_nxt.w_done = 1'b0;
      cur_nxt.bvalid = 1'b1;
      cur_nxt.bresp = 2'b00;
      if (cur_r.aw_addr == acte_pkg::ACTE_CFG_OFS)
        cur_nxt.cfg = 7'(acte_merge(32'(cur_r.cfg), cur_r.w_data, cur_r.w_strb));
      else if (cur_r.aw_addr == acte_pkg::ACTE_EXC_OFS)
        cur_nxt.exc = 13'(acte_merge(32'(cur_r.exc), cur_r.w_data, cur_r.w_strb));
      else if (cur_r.aw_addr == acte_pkg::ACTE_CMD_OFS)
      begin
        start_cmd = wval[acte_pkg::ACTE_CMD_START_BIT];
        sleep_cmd = wval[acte_pkg::ACTE_CMD_SLEEP_BIT];
      end
      else if (cur_r.aw_addr == acte_pkg::ACTE_IRQ_EN_OFS)
        cur_nxt.irq_en = 2'(acte_merge(32'(cur_r.irq_en), cur_r.w_data, cur_r.w_strb));
      else if (cur_r.aw_addr == acte_pkg::ACTE_IRQ_CLR_OFS)
        cur_nxt.irq_stat = cur_r.irq_stat & ~wval[1:0];
      else if (cur_r.aw_addr != acte_pkg::ACTE_STAT_OFS
               && cur_r.aw_addr != acte_pkg::ACTE_IRQ_STAT_OFS
               && cur_r.aw_addr != acte_pkg::ACTE_RESULT_OFS)
        cur_nxt.bresp = 2'b10; // unmapped address
    end
    // read decode; one cycle to answer
    if (rd_go)
    begin
      cur_nxt.rvalid = 1'b1;
      cur_nxt.rresp = 2'b00;
      cur_nxt.rdata = 32'h0;
      if (S_AXI_ARADDR == acte_pkg::ACTE_CFG_OFS)
        cur_nxt.rdata = 32'(cur_r.cfg);
      else if (S_AXI_ARADDR == acte_pkg::ACTE_EXC_OFS)
        cur_nxt.rdata = 32'(cur_r.exc);
      else if (S_AXI_ARADDR == acte_pkg::ACTE_CMD_OFS)
        cur_nxt.rdata = 32'h0;
      else if (S_AXI_ARADDR == acte_pkg::ACTE_STAT_OFS)
        cur_nxt.rdata = {28'h0, cur_r.powered, ~cur_r.rdy_n, cur_r.st};
      else if (S_AXI_ARADDR == acte_pkg::ACTE_IRQ_STAT_OFS)
        cur_nxt.rdata = 32'(cur_r.irq_stat);
      else if (S_AXI_ARADDR == acte_pkg::ACTE_IRQ_EN_OFS)
        cur_nxt.rdata = 32'(cur_r.irq_en);
      else if (S_AXI_ARADDR == acte_pkg::ACTE_IRQ_CLR_OFS)
        cur_nxt.rdata = 32'h0;
      else if (S_AXI_ARADDR == acte_pkg::ACTE_RESULT_OFS)
      begin
        cur_nxt.rdata = 32'(cur_r.result_cnt);
        result_read = 1'b1;
      end
      else
        cur_nxt.rresp = 2'b10;
    end
    // oscillator: accumulator emits half-period ticks at mode rate [R2] [R4]
    // limitation: ticks land on core edges, so each half period jitters by one cycle
    phase_sum = {1'b0, cur_r.phase} +
      {1'b0, fast ? acte_pkg::ACTE_STEP_FAST : acte_pkg::ACTE_STEP_NORM};
    osc_tick = phase_sum[24];
    cur_nxt.phase = {8'h0, phase_sum[23:0]};
    if (osc_tick)
    begin
      cur_nxt.osc = ~cur_r.osc;
      // modulator toggles every 2 oscillator cycles -> divide by four [R1]
      if (cur_r.osc)
      begin
        cur_nxt.mod_div = cur_r.mod_div + 2'h1;
        if (cur_r.mod_div[0])
          cur_nxt.mod_clk = ~cur_r.mod_clk;
      end
    end
    // excitation power follows magnitude, dropped by sleep [R14] [R15]
    if (sleep_cmd)
      cur_nxt.powered = 1'b0;
    else if (wr_go && cur_r.aw_addr == acte_pkg::ACTE_EXC_OFS)
      cur_nxt.powered = 1'b1;
    // conversion sequencer; counts half oscillator periods
    case (cur_r.st)
      acte_pkg::ACTE_IDLE:
        ;
      acte_pkg::ACTE_DELAY:
        if (osc_tick)
        begin
          if (cur_r.half_cnt <= 18'h1)
          begin
            cur_nxt.st = acte_pkg::ACTE_CONV;
            cur_nxt.half_cnt = {acte_conv_len(rate, 1'b0, fast), 1'b0}; // [R7]
          end
          else
            cur_nxt.half_cnt = cur_r.half_cnt - 18'h1;
        end
      default:
        if (osc_tick)
        begin
          if (cur_r.half_cnt <= 18'h1)
          begin
            // full result ready after one period, filter settled [R3]
            done_ev = 1'b1;
            cur_nxt.rdy_n = 1'b0; // [R5] [R18]
            cur_nxt.result_cnt = cur_r.result_cnt + 8'h1;
            if (single)
              cur_nxt.st = acte_pkg::ACTE_IDLE;
            else
              cur_nxt.half_cnt = {acte_conv_len(rate, 1'b0, fast), 1'b0};
          end
          else
          begin
            cur_nxt.half_cnt = cur_r.half_cnt - 18'h1;
            // back high one oscillator cycle into the next conversion [R18]
            if (cur_r.half_cnt[17:1] == acte_conv_len(rate, 1'b0, fast) - 17'd1)
              cur_nxt.rdy_n = 1'b1;
          end
        end
    endcase
    if (result_read)
      cur_nxt.rdy_n = 1'b1; // [R18]
    // start latched when the command write completes [R10]
    if (start_cmd)
    begin
      start_ev = 1'b1;
      cur_nxt.rdy_n = 1'b1;
      if (single)
      begin
        cur_nxt.st = acte_pkg::ACTE_CONV;
        cur_nxt.half_cnt = {acte_conv_len(rate, 1'b1, fast), 1'b0}; // [R8] [R9]
      end
      else
      begin
        cur_nxt.st = acte_pkg::ACTE_DELAY;
        cur_nxt.half_cnt = fast ? acte_pkg::ACTE_FIRST_HALF_FAST
                                : acte_pkg::ACTE_FIRST_HALF_NORM; // [R6]
      end
    end
    else if (sleep_cmd)
      cur_nxt.st = acte_pkg::ACTE_IDLE;
    // sticky events; set wins over a clear in the same cycle
    if (done_ev)
      cur_nxt.irq_stat[acte_pkg::ACTE_IRQ_DONE_BIT] = 1'b1;
    if (start_ev)
      cur_nxt.irq_stat[acte_pkg::ACTE_IRQ_START_BIT] = 1'b1;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      cur_r <= '0;
      cur_r.cfg <= acte_pkg::ACTE_CFG_RST;
      cur_r.exc <= acte_pkg::ACTE_EXC_RST;
      cur_r.irq_en <= acte_pkg::ACTE_IRQ_EN_RST;
      cur_r.st <= acte_pkg::ACTE_IDLE;
      cur_r.rdy_n <= 1'b1;
    end
    else
      cur_r <= cur_nxt;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // channel readies are combinational, payloads from flops
  assign S_AXI_AWREADY = !cur_r.aw_done;
  assign S_AXI_WREADY = !cur_r.w_done;
  assign S_AXI_BVALID = cur_r.bvalid;
  assign S_AXI_BRESP = cur_r.bresp;
  assign S_AXI_ARREADY = !cur_r.rvalid;
  assign S_AXI_RVALID = cur_r.rvalid;
  assign S_AXI_RDATA = cur_r.rdata;
  assign S_AXI_RRESP = cur_r.rresp;
  assign RESULT_READY_N = cur_r.rdy_n;
  assign MOD_CLK = cur_r.mod_clk;
  // source on only when magnitude nonzero and not asleep [R11] [R15]
  assign EXC_BIAS_ON = cur_r.powered && (cur_r.exc[acte_pkg::ACTE_EXC_MAG_LSB +: 3] != 3'h0);
  assign EXCITATION_MAGNITUDE = EXC_BIAS_ON ? cur_r.exc[acte_pkg::ACTE_EXC_MAG_LSB +: 3] : 3'h0;
  // zero route means unrouted; both may share a pin [R12]
  assign EXCITATION1_ROUTE = EXC_BIAS_ON ? cur_r.exc[acte_pkg::ACTE_EXC_R1_LSB +: 3] : 3'h0;
  assign EXCITATION2_ROUTE = EXC_BIAS_ON ? cur_r.exc[acte_pkg::ACTE_EXC_R2_LSB +: 3] : 3'h0;
  assign BURNOUT_ENABLE = cur_r.exc[acte_pkg::ACTE_EXC_BURN_BIT]; // [R16]
  assign IRQ = |(cur_r.irq_stat & cur_r.irq_en);
endmodule

// ==== test/acte_checker.sv ====
// checker for the conversion timing and excitation block
// assumes it is bound to acte_ctrl and sees its ports only
module acte_checker (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic S_AXI_WVALID,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic RESULT_READY_N,
  input wire logic EXC_BIAS_ON,
  input wire logic [2:0] EXCITATION_MAGNITUDE,
  input wire logic [2:0] EXCITATION1_ROUTE,
  input wire logic [2:0] EXCITATION2_ROUTE,
  input wire logic BURNOUT_ENABLE
);
  logic [16:0] gap_r;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // cycles since the last result edge, saturating so reset never looks like a short gap
  always_ff @(posedge CORE_CLK or negedge RESET_N)
    if (!RESET_N)
      gap_r <= 17'h1ffff;
    else if ($fell(RESULT_READY_N))
      gap_r <= 17'h0;
    else if (gap_r != 17'h1ffff)
      gap_r <= gap_r + 17'h1;
  // ****
  // rules
  // ****
  bias_needs_mag_a: assert property (EXC_BIAS_ON |-> EXCITATION_MAGNITUDE != 3'h0)
    else $error("bias on with zero magnitude");
  off_means_zero_a: assert property (!EXC_BIAS_ON |->
    {EXCITATION_MAGNITUDE, EXCITATION1_ROUTE, EXCITATION2_ROUTE} == 9'h0)
    else $error("excitation fields while unpowered");
  ready_release_a: assert property ($fell(RESULT_READY_N) |-> ##[1:130] RESULT_READY_N)
    else $error("result ready held too long");
  ready_gap_a: assert property ($fell(RESULT_READY_N) |-> gap_r >= 17'hea60)
    else $error("results closer than fastest period");
  exc_by_write_a: assert property ($changed({EXC_BIAS_ON, BURNOUT_ENABLE,
    EXCITATION_MAGNITUDE, EXCITATION1_ROUTE, EXCITATION2_ROUTE}) |->
    $past(S_AXI_WVALID) || $past(S_AXI_WVALID, 2) || $past(S_AXI_WVALID, 3))
    else $error("excitation changed without a write");
  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while busy");
endmodule
bind acte_ctrl acte_checker i_acte_checker (.CORE_CLK, .RESET_N, .S_AXI_WVALID,
  .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARREADY, .S_AXI_RDATA,
  .S_AXI_RVALID, .S_AXI_RREADY, .RESULT_READY_N, .EXC_BIAS_ON, .EXCITATION_MAGNITUDE,
  .EXCITATION1_ROUTE, .EXCITATION2_ROUTE, .BURNOUT_ENABLE);

// ==== test/acte_host_model.sv ====
// host model: register master speaking AXI4-Lite to the block
// assumes clock from the bench; one transfer at a time
module acte_host_model #(
  parameter int EXC_WAIT = 25000
) (
  input wire logic CORE_CLK,
  output logic [7:0] S_AXI_AWADDR,
  output logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  output logic [31:0] S_AXI_WDATA,
  output logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  output logic S_AXI_BREADY,
  output logic [7:0] S_AXI_ARADDR,
  output logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  output logic S_AXI_RREADY
);
  initial
  begin
    {S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WSTRB, S_AXI_WVALID} = '0;
    {S_AXI_BREADY, S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} = '0;
  end
  // address and data go together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge CORE_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= 4'hf;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    do
    begin
      @(posedge CORE_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      r = S_AXI_BRESP;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge CORE_CLK);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do
    begin
      @(posedge CORE_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      d = S_AXI_RDATA;
      r = S_AXI_RRESP;
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
  endtask
  // magnitude first, routes only after start-up, else current is off spec
  task automatic exc_set(input logic [12:0] v, output logic [1:0] r);
    wr(acte_pkg::ACTE_EXC_OFS, {29'h0, v[2:0]}, r);
    repeat (EXC_WAIT) @(posedge CORE_CLK);
    wr(acte_pkg::ACTE_EXC_OFS, {19'h0, v}, r);
  endtask
endmodule

// ==== test/acte_ctrl_tb_top.sv ====
// bench top: resets the block, sweeps excitation, times conversions
// assumes the host model and the bound checker
module acte_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CORE_CLK, RESET_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic S_AXI_RREADY, RESULT_READY_N, MOD_CLK, EXC_BIAS_ON, BURNOUT_ENABLE, IRQ;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d, lf = 32'h2887;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  logic [2:0] EXCITATION_MAGNITUDE, EXCITATION1_ROUTE, EXCITATION2_ROUTE;
  logic [12:0] v;
  int err_total = 0, n_checks = 0, cyc = 0, t0, p;
  acte_ctrl i_acte_ctrl (.CORE_CLK, .RESET_N, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
    .RESULT_READY_N, .MOD_CLK, .EXC_BIAS_ON, .EXCITATION_MAGNITUDE, .EXCITATION1_ROUTE,
    .EXCITATION2_ROUTE, .BURNOUT_ENABLE, .IRQ);
  // start-up wait shortened to 2 us to keep the run short
  acte_host_model #(.EXC_WAIT(250)) i_acte_host_model (.CORE_CLK, .S_AXI_AWADDR,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
    .S_AXI_RREADY);
  // ****
  // clock, cycle count, watchdog
  // ****
  initial
  begin
    CORE_CLK = 1'b0;
    forever #4 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) cyc <= cyc + 1;
  // about 75k cycles are needed; the slowest timing step dominates
  initial
  begin
    #760000;
    err_total++;
    results();
  end
  // ****
  // helpers
  // ****
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // core cycles for a count of oscillator half periods
  function automatic int exp_cyc(input int halves, input bit fast);
    longint hz = fast ? acte_pkg::ACTE_OSC_FAST_HZ : acte_pkg::ACTE_OSC_NORM_HZ;
    return int'(longint'(halves) * acte_pkg::ACTE_CORE_HZ / (2 * hz));
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic near(input int seen, input int exp, input int tol);
    chk(32'(seen >= exp - tol && seen <= exp + tol), 32'h1);
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] x);
    i_acte_host_model.wr(a, x, r);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    i_acte_host_model.rd(a, d, r);
    chk(d, x);
  endtask
  task automatic do_reset();
    RESET_N <= 1'b0;
    repeat (16) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    @(negedge CORE_CLK);
  endtask
  // one modulator period in core cycles, jitter of two cycles allowed
  task automatic mod_per(input bit fast);
    @(posedge MOD_CLK);
    p = cyc;
    @(posedge MOD_CLK);
    near(cyc - p, exp_cyc(8, fast), 2);
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    RESET_N = 1'b0;
    do_reset();
    chk(RESULT_READY_N, 1'b1);
    chk(EXC_BIAS_ON, 1'b0);
    rchk(acte_pkg::ACTE_CFG_OFS, 32'h0);
    rchk(acte_pkg::ACTE_EXC_OFS, 32'h0);
    rchk(acte_pkg::ACTE_IRQ_EN_OFS, 32'h0);
    rchk(8'h20, 32'h0);
    chk(r, 2'h2);
    w(8'h24, 32'h0);
    chk(r, 2'h2);
    // every magnitude code, random routes, both sources on one pin once
    for (int m = 0; m < 8; m++)
    begin
      lf = lfsr_next(lf);
      v = {lf[12], 1'b0, (m == 5) ? lf[6:4] : lf[10:8], 1'b0, lf[6:4], 1'b0, 3'(m)};
      i_acte_host_model.exc_set(v, r);
      @(negedge CORE_CLK);
      chk(EXC_BIAS_ON, m != 0);
      chk({EXCITATION_MAGNITUDE, EXCITATION1_ROUTE, EXCITATION2_ROUTE},
        (m != 0) ? {v[2:0], v[6:4], v[10:8]} : 9'h0);
      chk(BURNOUT_ENABLE, v[12]);
    end
    i_acte_host_model.exc_set(13'h0011, r);
    w(acte_pkg::ACTE_CMD_OFS, 32'h2);
    @(negedge CORE_CLK);
    chk({EXC_BIAS_ON, EXCITATION_MAGNITUDE, EXCITATION1_ROUTE}, 7'h0);
    // continuous normal: start delay, start interrupt raised, masked, cleared
    w(acte_pkg::ACTE_IRQ_EN_OFS, 32'h2);
    w(acte_pkg::ACTE_CFG_OFS, 32'h60);
    w(acte_pkg::ACTE_CMD_OFS, 32'h1);
    t0 = cyc;
    rchk(acte_pkg::ACTE_STAT_OFS, 32'h1);
    while (d[1:0] !== 2'h2) i_acte_host_model.rd(acte_pkg::ACTE_STAT_OFS, d, r);
    near(cyc - t0, exp_cyc(57, 0), 80);
    chk(IRQ, 1'b1);
    rchk(acte_pkg::ACTE_IRQ_STAT_OFS, 32'h2);
    w(acte_pkg::ACTE_IRQ_EN_OFS, 32'h0);
    @(negedge CORE_CLK);
    chk(IRQ, 1'b0);
    w(acte_pkg::ACTE_IRQ_EN_OFS, 32'h2);
    @(negedge CORE_CLK);
    chk(IRQ, 1'b1);
    w(acte_pkg::ACTE_IRQ_CLR_OFS, 32'h2);
    @(negedge CORE_CLK);
    chk(IRQ, 1'b0);
    mod_per(1'b0);
    // reset in mid-run aborts the running conversion
    do_reset();
    chk(RESULT_READY_N, 1'b1);
    // single shot, fast mode, fastest rate, excitation kept powered
    w(acte_pkg::ACTE_CFG_OFS, 32'h63);
    i_acte_host_model.exc_set(13'h0011, r);
    w(acte_pkg::ACTE_IRQ_EN_OFS, 32'h1);
    mod_per(1'b1);
    w(acte_pkg::ACTE_CMD_OFS, 32'h1);
    t0 = cyc;
    while (RESULT_READY_N !== 1'b0) @(negedge CORE_CLK);
    near(cyc - t0, exp_cyc(2130, 1), 75);
    chk(IRQ, 1'b1);
    rchk(acte_pkg::ACTE_RESULT_OFS, 32'h1);
    @(negedge CORE_CLK);
    chk(RESULT_READY_N, 1'b1);
    chk(EXC_BIAS_ON, 1'b1);
    results();
  end
  task automatic results();
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
endmodule
